// >>> host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic                     clock_i,
  input  wire logic [31:0]              rdata_i,
  input  wire logic                     rdata_valid_i,
  output var  host_regs_pkg::host_req_t req_o,
  output logic                          sync_xfer_o,
  output logic                          async_xfer_o
);
  import host_regs_pkg::*;

  // bus idle at time zero
  initial begin
    req_o = '0;
    sync_xfer_o = 1'b0;
    async_xfer_o = 1'b0;
  end

  // one request held over exactly one taking edge; callers write reserved bits without reading them first
  task automatic access(input logic [15:0] a, input logic [3:0] be, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = '0;
    @(posedge clock_i);
    req_o <= '{addr: a, be: be, wr: wr, rd: ~wr, wdata: wd};
    @(posedge clock_i);
    // released lines show a changed pattern so stale values never pass
    req_o <= '{addr: ~a, be: ~be, wr: 1'b0, rd: 1'b0, wdata: ~wd};
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clock_i);
      ok = wr | rdata_valid_i;
      rd = rdata_i;
    end
  endtask : access

  // transfer-kind levels, changed at a rising edge
  task automatic set_xfer(input logic s, input logic a);
    @(posedge clock_i);
    sync_xfer_o <= s;
    async_xfer_o <= a;
  endtask : set_xfer
endmodule : host_bus_model
`default_nettype wire

// >>> host_register_bank_control.sv
// Overview of operation
// R1: software reads reserved bits first and writes them back unchanged; the testbench writes them without reading first.
// R2: writing one clears a write-one-to-clear bit; writing zero leaves it.
// R3: bank number field is bits 5-0, 64 banks; bits 15-6 read zero.
// R4: bank selector decodes at the same offset in every bank.
// R5: bank selector reachable as dword at 0xC, word or byte at 0xE.
// R6: dword write at 0xC changes only 0xE, bytes 0xC and 0xD untouched.
// R7: bank number field is zero after reset.
// R8: strap high loads base from eeprom word 0; host may overwrite.
// R9: strap low gives base 0x300: high field 0x03, low field zero.
// R10: host write to base never starts an eeprom write.
// R11: base bits 15-8 compared with host address bits 15-8.
// R12: base bits 7-5 compared with address 7-5; bits 4-0 read zero.
// R13: watermark bit 12 resets 0; 0 selects 3 KBytes, 1 selects 2 KBytes.
// R14: illegal byte enables set flag bit 15, cleared by writing one.
// R15: offending byte enables captured in bits 14-11, lane 3 at bit 14.
// R16: simultaneous sync and async transfers set bit 10, write one clears.
// R17: non-aligned byte enable patterns are illegal; first pattern kept until clear.
// R18: writes to read-only bits ignored; reserved fields read zero.
`timescale 1ns/1ps
`default_nettype none
module host_register_bank_control (
  input  wire logic                    clock_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    ce_i,
  input  wire host_regs_pkg::host_req_t host_req_i,
  input  wire logic                    sync_xfer_i,
  input  wire logic                    async_xfer_i,
  input  wire logic                    eeprom_enable_strap_i,
  input  wire logic                    eeprom_load_i,
  input  wire logic [15:0]             eeprom_word0_i,
  output logic                         window_hit_o,
  output logic [31:0]                  rdata_o,
  output logic                         rdata_valid_o,
  output logic [5:0]                   bank_o,
  output logic [15:0]                  base_o,
  output logic                         watermark_2k_o,
  output logic                         bad_lane_flag_o,
  output logic                         mixed_transfer_flag_o
);
  import host_regs_pkg::*;

  // all block state except the two sticky error flags in one word
  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [BASE_W-1:0] base;
    logic              wmark;
    logic              strap_seen;
    logic              strap;
    logic              loaded;
    logic [31:0]       rdata;
    logic              rvalid;
  } bank_state_t;

  localparam bank_state_t STATE_RESET = '{
    bank:       BANK_RESET,
    base:       BASE_DEFAULT[15:BASE_LSB],
    wmark:      WMARK_RESET,
    strap_seen: 1'b0,
    strap:      1'b0,
    loaded:     1'b0,
    rdata:      32'h0000_0000,
    rvalid:     1'b0
  };

  bank_state_t st_r;
  bank_state_t st_nxt;

  logic        legal;
  logic        hit;
  logic        access;
  logic        good;
  logic        bad;
  logic        bank0;
  logic [1:0]  dw;
  logic        load_ok;
  logic        clr_bad;
  logic        clr_mix;
  logic        mix_event;
  logic [3:0]  bad_pattern;
  logic [3:0]  err_pattern;
  logic [31:0] lane_mask;
  logic [31:0] rd_word;
  logic [15:0] err_word;

  // lane legality of the current request
  lane_check u_lane_check (
    .be_i    (host_req_i.be),
    .legal_o (legal)
  );

  // window decode: upper address bits against the live base
  always_comb begin
    hit = (host_req_i.addr[15:8] == st_r.base[BASE_W-1:3])  // R11
        && (host_req_i.addr[7:5] == st_r.base[2:0])          // R12
        && !host_req_i.addr[4];
  end

  // request classification
  assign access = hit && (host_req_i.wr || host_req_i.rd);
  assign good   = access && legal;
  assign bad    = access && !legal;  // R14
  assign dw     = host_req_i.addr[3:2];
  assign bank0  = (st_r.bank == BANK_RESET);

  // lane 3 of the request lands in bit 3 of the capture
  assign bad_pattern = host_req_i.be;  // R15

  // write-one-to-clear strobes for the error status at 0x06
  always_comb begin
    clr_bad = good && host_req_i.wr && bank0 && (dw == DW_STAT) && host_req_i.be[3]
            && host_req_i.wdata[ERR_LSB + BAD_FLAG_BIT];  // R2
    clr_mix = good && host_req_i.wr && bank0 && (dw == DW_STAT) && host_req_i.be[3]
            && host_req_i.wdata[ERR_LSB + MIX_FLAG_BIT];  // R2
  end

  // both transfer kinds at once is a bus misuse
  assign mix_event = sync_xfer_i && async_xfer_i;  // R16

  // illegal lane flag with its captured pattern
  sticky_flag #(
    .W (4)
  ) u_bad_lane (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .set_i     (bad),
    .clr_i     (clr_bad),
    .data_i    (bad_pattern),
    .flag_o    (bad_lane_flag_o),
    .data_o    (err_pattern)
  );

  // mixed transfer flag carries no payload
  sticky_flag #(
    .W (1)
  ) u_mixed (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .set_i     (mix_event),
    .clr_i     (clr_mix),
    .data_i    (1'b0),
    .flag_o    (mixed_transfer_flag_o),
    .data_o    ()
  );

  // error status image; reserved bits 9-0 read zero
  assign err_word = {bad_lane_flag_o, err_pattern, mixed_transfer_flag_o, 10'h000};  // R18

  // byte lanes expanded to a bit mask
  always_comb begin
    lane_mask = {{8{host_req_i.be[3]}}, {8{host_req_i.be[2]}},
                 {8{host_req_i.be[1]}}, {8{host_req_i.be[0]}}};
  end

  // read mux; bank 0 registers only in bank 0, selector in every bank
  always_comb begin
    rd_word = 32'h0000_0000;
    case (dw)
      DW_BASE: begin
        if (bank0) begin
          rd_word = {16'h0000, st_r.base, 5'h00};  // R12
        end
      end
      DW_STAT: begin
        if (bank0) begin
          rd_word = {err_word, 3'h0, st_r.wmark, 12'h000};  // R18
        end
      end
      DW_BANK: begin
        rd_word = {10'h000, st_r.bank, 16'h0000};  // R4
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // eeprom word 0 is taken once, only when the strap was high at start
  assign load_ok = eeprom_load_i && st_r.strap_seen && st_r.strap && !st_r.loaded;  // R8

  // next state of the register bank
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    // strap sampled once on the first enabled edge after reset
    if (!st_r.strap_seen) begin
      st_nxt.strap_seen = 1'b1;
      st_nxt.strap      = eeprom_enable_strap_i;
    end
    if (load_ok) begin
      st_nxt.base   = eeprom_word0_i[15:BASE_LSB];  // R8
      st_nxt.loaded = 1'b1;
    end
    if (good && host_req_i.wr) begin
      // base: lane 1 carries bits 15-8, lane 0 bits 7-5; nothing goes to the eeprom
      if (bank0 && (dw == DW_BASE)) begin
        if (host_req_i.be[1]) begin
          st_nxt.base[BASE_W-1:3] = host_req_i.wdata[15:8];  // R10
        end
        if (host_req_i.be[0]) begin
          st_nxt.base[2:0] = host_req_i.wdata[7:5];  // R12
        end
      end
      // watermark select lives on lane 1 of dword 1
      if (bank0 && (dw == DW_STAT) && host_req_i.be[1]) begin
        st_nxt.wmark = host_req_i.wdata[WMARK_BIT];  // R13
      end
      // selector: only lane 2 stores, lanes 0, 1 and 3 are dropped
      if ((dw == DW_BANK) && host_req_i.be[2]) begin
        st_nxt.bank = host_req_i.wdata[BANK_LSB +: BANK_W];  // R5 R6
      end
    end
    // every read of the window answers one cycle later, zero if illegal
    if (access && host_req_i.rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = good ? (rd_word & lane_mask) : 32'h0000_0000;
    end
  end

  // state register; reset wins over the clock enable
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_r <= STATE_RESET;  // R7 R9
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state, except the window hit, which is combinational from the request
  assign window_hit_o   = hit;
  assign rdata_o        = st_r.rdata;
  assign rdata_valid_o  = st_r.rvalid;
  assign bank_o         = st_r.bank;  // R3
  assign base_o         = {st_r.base, 5'h00};
  assign watermark_2k_o = st_r.wmark;  // R13

  // checks on the bank
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  logic [31:0] wdata_q;
  logic        bank_wr_q;
  logic        bank_rd_q;

  // helper capture of the previous request; cleared in reset so no stale strobe fires after it
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wdata_q   <= 32'h0000_0000;
      bank_wr_q <= 1'b0;
      bank_rd_q <= 1'b0;
    end else begin
      wdata_q   <= host_req_i.wdata;
      bank_wr_q <= ce_i && good && host_req_i.wr && (dw == DW_BANK) && host_req_i.be[2];
      bank_rd_q <= ce_i && good && host_req_i.rd && (dw == DW_BANK);
    end
  end

  bank_reset_a: assert property (disable iff (1'b0) sys_rst_i |=> bank_o == 6'h00) // R7
    else $error("bank not zero after reset");

  base_default_a: assert property (disable iff (1'b0) sys_rst_i |=> base_o == 16'h0300) // R9
    else $error("base not 0x300 after reset");

  bank_write_a: assert property (bank_wr_q |-> bank_o == wdata_q[21:16]) // R3
    else $error("selector write not stored");

  bank_readback_a: assert property (bank_rd_q |-> rdata_valid_o && rdata_o[15:0] == 16'h0000
                                    && rdata_o[31:22] == 10'h000) // R6
    else $error("reserved bytes of the selector dword not zero");

  base_reserved_a: assert property (base_o[4:0] == 5'h00) // R12
    else $error("base reserved bits not zero");

  hit_match_a: assert property (window_hit_o |-> host_req_i.addr[15:5] == base_o[15:5]) // R11
    else $error("window hit without base match");

  eeprom_load_a: assert property (ce_i && load_ok && !(good && host_req_i.wr)
                                  |=> base_o == ($past(eeprom_word0_i) & BASE_MASK) && st_r.loaded) // R8
    else $error("eeprom word 0 not loaded into base");

  wmark_write_a: assert property (ce_i && good && host_req_i.wr && bank0 && dw == 2'h1
                                  && host_req_i.be[1] |=> watermark_2k_o == $past(host_req_i.wdata[12])) // R13
    else $error("watermark select not written");

  bad_lane_a: assert property (ce_i && bad |=> bad_lane_flag_o) // R14
    else $error("illegal byte enables did not set the flag");

  bad_capture_a: assert property (ce_i && bad && !bad_lane_flag_o
                                  |=> err_pattern == $past(host_req_i.be)) // R15
    else $error("offending byte enables not captured");

  mixed_flag_a: assert property (ce_i && mix_event |=> mixed_transfer_flag_o) // R16
    else $error("mixed transfer flag not set");

  bad_ignored_a: assert property (ce_i && bad |=> $stable(bank_o) && $stable(base_o)
                                  && $stable(watermark_2k_o)) // R17
    else $error("illegal access changed a register");

  read_answer_a: assert property (ce_i && access && host_req_i.rd |=> rdata_valid_o ##1 !rdata_valid_o
                                  or (ce_i && access && host_req_i.rd)) // R18
    else $error("read answer not a one-cycle pulse");

  // a miss gets no answer and an illegal read answers zero
  miss_silent_a: assert property (ce_i && !access |=> !rdata_valid_o) // R11
    else $error("answer without a window hit");

  illegal_zero_a: assert property (ce_i && bad && host_req_i.rd // R17
                                   |=> rdata_valid_o && rdata_o == 32'h0000_0000)
    else $error("illegal read returned data");

  // host write to base lands in the live register only
  base_write_a: assert property (ce_i && good && host_req_i.wr && bank0 && dw == DW_BASE && host_req_i.be[1] // R10
                                 |=> base_o[15:8] == $past(host_req_i.wdata[15:8]))
    else $error("base high field not written");

  // write-one clears unless a new event arrives in the same cycle
  bad_clear_a: assert property (ce_i && clr_bad |=> !bad_lane_flag_o) // R14
    else $error("bad lane flag not cleared");

  mixed_clear_a: assert property (ce_i && clr_mix && !mix_event |=> !mixed_transfer_flag_o) // R16
    else $error("mixed transfer flag not cleared");

  flags_reset_a: assert property (disable iff (1'b0) sys_rst_i // R13
                                  |=> !watermark_2k_o && !bad_lane_flag_o && !mixed_transfer_flag_o)
    else $error("watermark or flags not zero after reset");

  // clock enable low holds every register, the read answer included
  ce_freeze_a: assert property (!ce_i |=> $stable(bank_o) && $stable(base_o) && $stable(watermark_2k_o)
                                && $stable(bad_lane_flag_o) && $stable(mixed_transfer_flag_o)
                                && $stable(rdata_valid_o))
    else $error("state moved while the clock enable was low");

  bank_switch_c: cover property (ce_i && good && host_req_i.wr && dw == 2'h3 && host_req_i.be[2]
                                 && host_req_i.wdata[21:16] != 6'h00);
  bad_lane_c: cover property (ce_i && bad ##1 bad_lane_flag_o ##[1:20] !bad_lane_flag_o);
  eeprom_load_c: cover property (ce_i && load_ok);
  mixed_clear_c: cover property (ce_i && clr_mix && mixed_transfer_flag_o);
  readback_c: cover property (ce_i && good && host_req_i.rd ##1 rdata_valid_o);
endmodule : host_register_bank_control
`default_nettype wire

// >>> host_regs_pkg.sv
`default_nettype none
package host_regs_pkg;

  // host bus word and lane geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES  = 4;

  // register byte offsets inside the 16-byte window
  localparam logic [3:0] OFS_BASE    = 4'h0;
  localparam logic [3:0] OFS_WMARK   = 4'h4;
  localparam logic [3:0] OFS_ERR     = 4'h6;
  localparam logic [3:0] OFS_BANK_DW = 4'hc;
  localparam logic [3:0] OFS_BANK    = 4'he;

  // dword index of each register group
  localparam logic [1:0] DW_BASE = 2'h0;
  localparam logic [1:0] DW_STAT = 2'h1;
  localparam logic [1:0] DW_BANK = 2'h3;

  // bank selector field
  localparam int          BANK_W     = 6;
  localparam logic [5:0]  BANK_RESET = 6'h00;
  localparam int          BANK_LSB   = 16;   // 0xe sits on lanes 3:2

  // base address field: bits 15-5 kept, 4-0 reserved
  localparam int           BASE_W       = 11;
  localparam int           BASE_LSB     = 5;
  localparam logic [15:0]  BASE_DEFAULT = 16'h0300;
  localparam logic [15:0]  BASE_MASK    = 16'hffe0;

  // watermark select, bit 12 of the register at 0x04 (lanes 1:0)
  localparam int   WMARK_BIT   = 12;
  localparam logic WMARK_RESET = 1'b0;

  // error status at 0x06, lanes 3:2 of dword 1
  localparam int ERR_LSB      = 16;
  localparam int BAD_FLAG_BIT = 15;
  localparam int BAD_PAT_LSB  = 11;
  localparam int MIX_FLAG_BIT = 10;

  // host request bundle
  typedef struct packed {
    logic [15:0] addr;
    logic [3:0]  be;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } host_req_t;

endpackage : host_regs_pkg
`default_nettype wire

// >>> lane_check.sv
`timescale 1ns/1ps
`default_nettype none
module lane_check (
  input  wire logic [3:0] be_i,
  output logic            legal_o
);
  // only aligned byte, word and dword patterns are legal
  always_comb begin
    case (be_i)
      4'h1, 4'h2, 4'h4, 4'h8: legal_o = 1'b1;
      4'h3, 4'hc:             legal_o = 1'b1;
      4'hf:                   legal_o = 1'b1;
      default:                legal_o = 1'b0;  // R17
    endcase
  end
endmodule : lane_check
`default_nettype wire

// >>> sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_flag #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire logic         set_i,
  input  wire logic         clr_i,
  input  wire logic [W-1:0] data_i,
  output logic              flag_o,
  output logic [W-1:0]      data_o
);
  typedef struct packed {
    logic         flag;
    logic [W-1:0] data;
  } flag_state_t;

  flag_state_t st_r;
  flag_state_t st_nxt;

  // set beats clear so an event in the clearing cycle is not lost
  always_comb begin
    st_nxt = st_r;
    if (set_i && (!st_r.flag || clr_i)) begin
      st_nxt.data = data_i;  // R17
    end
    st_nxt.flag = set_i | (st_r.flag & ~clr_i);  // R2
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign flag_o = st_r.flag;
  assign data_o = st_r.data;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  flag_holds_a: assert property (ce_i && flag_o && !clr_i |=> flag_o)  // R2
    else $error("sticky flag dropped without a clear");
  clear_wins_a: assert property (ce_i && flag_o && clr_i && !set_i |=> !flag_o)  // R2
    else $error("write one did not clear the flag");
  first_kept_a: assert property (ce_i && flag_o && !clr_i |=> $stable(data_o))  // R17
    else $error("captured data changed while flag set");
endmodule : sticky_flag
`default_nettype wire

// >>> tb_host_register_bank_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_host_register_bank_control;
  import host_regs_pkg::*;
  logic        clock_i;
  logic        sys_rst_i;
  logic        ce_i;
  logic        strap;
  logic        ee_load;
  logic [15:0] ee_word;
  host_req_t   req;
  logic        sync_x;
  logic        async_x;
  logic [31:0] rdata;
  logic        rvalid;
  logic [5:0]  bank;
  logic [15:0] base;
  logic        wm2k;
  logic        bad_flag;
  logic        mix_flag;
  logic        hit;
  logic        hit_seen;
  logic [31:0] rd;
  logic        ok;
  int          errors;
  int          checks_done;

  host_register_bank_control u_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .host_req_i(req),
    .sync_xfer_i(sync_x), .async_xfer_i(async_x), .eeprom_enable_strap_i(strap),
    .eeprom_load_i(ee_load), .eeprom_word0_i(ee_word), .window_hit_o(hit),
    .rdata_o(rdata), .rdata_valid_o(rvalid), .bank_o(bank), .base_o(base),
    .watermark_2k_o(wm2k), .bad_lane_flag_o(bad_flag), .mixed_transfer_flag_o(mix_flag)
  );

  host_bus_model u_host (
    .clock_i(clock_i), .rdata_i(rdata), .rdata_valid_i(rvalid), .req_o(req),
    .sync_xfer_o(sync_x), .async_xfer_o(async_x)
  );

  // window decode as seen at the edge that takes each request
  always_ff @(posedge clock_i) begin
    if (req.wr || req.rd) begin
      hit_seen <= hit;
    end
  end

  // 200 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
    u_host.access(a, be, 1'b1, d, rd, ok);
  endtask : wr

  // a read that must be answered; a missing answer ends the run
  task automatic rdx(input logic [15:0] a, input logic [3:0] be);
    u_host.access(a, be, 1'b0, 32'h0, rd, ok);
    check("read answer", 32'(ok), 32'h1);
    if (!ok) begin
      summarize();
    end
  endtask : rdx

  // reset held 20 cycles; strap set alongside
  task automatic do_reset(input logic s);
    @(posedge clock_i);
    strap <= s;
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
  endtask : do_reset

  task automatic t_reset();
    check("bank", 32'(bank), 32'h0);
    check("base", 32'(base), 32'h300);
    check("wmark", 32'(wm2k), 32'h0);
    check("bad", 32'(bad_flag), 32'h0);
    check("mix", 32'(mix_flag), 32'h0);
    rdx(16'h0300, 4'hf);
    check("base rd", rd, 32'h0000_0300);
    @(negedge clock_i);
    check("valid pulse", 32'(rvalid), 32'h0);
  endtask : t_reset

  task automatic t_bank();
    wr(16'h030c, 4'hf, 32'hffff_ffff);
    check("bank dw", 32'(bank), 32'h3f);
    rdx(16'h030c, 4'hf);
    check("bank rd", rd, 32'h003f_0000);
    wr(16'h030c, 4'hc, 32'h0015_0000);
    check("bank w", 32'(bank), 32'h15);
    wr(16'h030c, 4'h4, 32'h0022_0000);
    check("bank b", 32'(bank), 32'h22);
    rdx(16'h030c, 4'h4);
    check("bank any", rd, 32'h0022_0000);
    wr(16'h030c, 4'hf, 32'h0);
  endtask : t_bank

  task automatic t_base();
    wr(16'h0300, 4'h3, 32'hffff_04ff);
    check("base wr", 32'(base), 32'h04e0);
    rdx(16'h04e0, 4'h3);
    check("base rd2", rd, 32'h0000_04e0);
    check("new hit", 32'(hit_seen), 32'h1);
    u_host.access(16'h0300, 4'h3, 1'b0, 32'h0, rd, ok);
    check("old miss", 32'(ok), 32'h0);
    check("old hit", 32'(hit_seen), 32'h0);
    u_host.access(16'h04c0, 4'h3, 1'b0, 32'h0, rd, ok);
    check("b5 miss", 32'(ok), 32'h0);
    check("b5 hit", 32'(hit_seen), 32'h0);
    wr(16'h04e0, 4'h3, 32'h0000_0300);
  endtask : t_base

  task automatic t_wmark();
    wr(16'h0304, 4'h3, 32'hffff_ffff);
    check("wm set", 32'(wm2k), 32'h1);
    rdx(16'h0304, 4'h3);
    check("wm rd", rd, 32'h0000_1000);
    wr(16'h0304, 4'h3, 32'h0);
    check("wm clr", 32'(wm2k), 32'h0);
  endtask : t_wmark

  // illegal lanes: first pattern kept, write-one clears
  task automatic t_bad();
    rdx(16'h0300, 4'h5);
    check("ill rd", rd, 32'h0);
    check("bad set", 32'(bad_flag), 32'h1);
    wr(16'h0300, 4'h9, 32'hffff_ffff);
    check("no wr", 32'(base), 32'h300);
    rdx(16'h0304, 4'hc);
    check("pattern", rd, 32'ha800_0000);
    wr(16'h0304, 4'h8, 32'h7fff_ffff);
    check("w1c 0", 32'(bad_flag), 32'h1);
    wr(16'h0304, 4'h8, 32'h8000_0000);
    check("w1c 1", 32'(bad_flag), 32'h0);
  endtask : t_bad

  task automatic t_mixed();
    u_host.set_xfer(1'b1, 1'b0);
    rdx(16'h0300, 4'hf);
    check("sync only", 32'(mix_flag), 32'h0);
    u_host.set_xfer(1'b1, 1'b1);
    rdx(16'h0300, 4'hf);
    check("mixed", 32'(mix_flag), 32'h1);
    u_host.set_xfer(1'b0, 1'b0);
    wr(16'h0304, 4'h8, 32'h0400_0000);
    check("mix clr", 32'(mix_flag), 32'h0);
  endtask : t_mixed

  // clock enable low: a write and a mixed transfer leave every register alone
  task automatic t_freeze();
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr(16'h030c, 4'h4, 32'h0011_0000);
    check("frozen bank", 32'(bank), 32'h0);
    u_host.set_xfer(1'b1, 1'b1);
    u_host.set_xfer(1'b0, 1'b0);
    @(posedge clock_i);
    ce_i <= 1'b1;
    @(negedge clock_i);
    check("frozen mix", 32'(mix_flag), 32'h0);
    wr(16'h030c, 4'h4, 32'h0011_0000);
    check("thawed bank", 32'(bank), 32'h11);
  endtask : t_freeze

  // strap high: base comes from the loader, host may overwrite it
  task automatic t_eeprom();
    do_reset(1'b1);
    @(posedge clock_i);
    ee_word <= 16'h1234;
    ee_load <= 1'b1;
    @(posedge clock_i);
    ee_load <= 1'b0;
    @(negedge clock_i);
    check("ee base", 32'(base), 32'h1220);
    wr(16'h1220, 4'h3, 32'h0000_0300);
    check("overwrite", 32'(base), 32'h300);
  endtask : t_eeprom

  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    strap = 1'b0;
    ee_load = 1'b0;
    ee_word = 16'h0;
    do_reset(1'b0);
    t_reset();
    t_bank();
    t_base();
    t_wmark();
    t_bad();
    t_mixed();
    t_freeze();
    t_eeprom();
    summarize();
  end
endmodule : tb_host_register_bank_control
`default_nettype wire
